// ---- core/oam_map.svh ----
// Constant map for the operand address mode unit
`ifndef OAM_MAP_SVH
`define OAM_MAP_SVH
`define OAM_ZERO_PAGE_HI   16'h00ff
`define OAM_PC_RESET       16'h0000
`define OAM_MODE_COUNT     5'h11
`define OAM_MAX_OPND       2'h3
`define OAM_PAGE_ZERO_HI   8'h00
`endif

// ---- core/oam_pkg.sv ----
// Types for the operand address mode unit
package oam_pkg;
    typedef enum logic [4:0] {
        OAM_INH       = 5'h00,
        OAM_IMM       = 5'h01,
        OAM_DIR_S     = 5'h02,
        OAM_DIR_L     = 5'h03,
        OAM_IDX_N     = 5'h04,
        OAM_IDX_S     = 5'h05,
        OAM_IDX_L     = 5'h06,
        OAM_IND_S     = 5'h07,
        OAM_IND_L     = 5'h08,
        OAM_INDX_S    = 5'h09,
        OAM_INDX_L    = 5'h0a,
        OAM_REL_D     = 5'h0b,
        OAM_REL_I     = 5'h0c,
        OAM_BIT_D     = 5'h0d,
        OAM_BIT_I     = 5'h0e,
        OAM_BITREL_D  = 5'h0f,
        OAM_BITREL_I  = 5'h10
    } oam_mode_e;

    typedef enum logic [6:0] {
        OAM_ST_IDLE  = 7'h01,
        OAM_ST_OPC   = 7'h02,
        OAM_ST_OPA   = 7'h04,
        OAM_ST_OPB   = 7'h08,
        OAM_ST_PTRH  = 7'h10,
        OAM_ST_PTRL  = 7'h20,
        OAM_ST_DONE  = 7'h40
    } oam_state_e;
endpackage

// ---- core/oam_len.sv ----
// Operand byte count and family flags per addressing mode
`timescale 1ns/1ps
`default_nettype none
module oam_len
    import oam_pkg::*;
(
    input  wire oam_mode_e  mode_i,
    input  wire logic       use_y_i,
    output logic [1:0]      opnd_bytes_o,
    output logic            ptr_o,
    output logic            ptr_word_o,
    output logic            rmw_ok_o
);
    always_comb begin
        opnd_bytes_o = 2'h0;
        ptr_o        = 1'b0;
        ptr_word_o   = 1'b0;
        rmw_ok_o     = 1'b1;
        case (mode_i)
            OAM_INH:      opnd_bytes_o = 2'h0;
            OAM_IMM:      opnd_bytes_o = 2'h1;
            OAM_DIR_S:    opnd_bytes_o = 2'h1;
            OAM_DIR_L: begin
                opnd_bytes_o = 2'h2;
                rmw_ok_o     = 1'b0;
            end
            // Second index register costs one prefix byte
            OAM_IDX_N:    opnd_bytes_o = use_y_i ? 2'h1 : 2'h0;
            OAM_IDX_S:    opnd_bytes_o = 2'h1;
            OAM_IDX_L: begin
                opnd_bytes_o = 2'h2;
                rmw_ok_o     = 1'b0;
            end
            OAM_IND_S, OAM_INDX_S, OAM_REL_I, OAM_BIT_I: begin
                opnd_bytes_o = 2'h1;
                ptr_o        = 1'b1;
            end
            OAM_IND_L, OAM_INDX_L: begin
                opnd_bytes_o = 2'h1;
                ptr_o        = 1'b1;
                ptr_word_o   = 1'b1;
                rmw_ok_o     = 1'b0;
            end
            OAM_REL_D, OAM_BIT_D: opnd_bytes_o = 2'h1;
            OAM_BITREL_D: opnd_bytes_o = 2'h2;
            OAM_BITREL_I: begin
                opnd_bytes_o = 2'h2;
                ptr_o        = 1'b1;
            end
            default:      opnd_bytes_o = 2'h0;
        endcase
    end
endmodule
`default_nettype wire

// ---- core/oam_add.sv ----
// Effective address adder for indexed and relative forms
`timescale 1ns/1ps
`default_nettype none
module oam_add (
    input  wire logic [15:0] base_i,
    input  wire logic [7:0]  index_i,
    input  wire logic        signed_i,
    output logic [15:0]      sum_o
);
    logic [15:0] ext;
    always_comb begin
        ext   = signed_i ? {{8{index_i[7]}}, index_i} : {8'h00, index_i};
        sum_o = base_i + ext;
    end
endmodule
`default_nettype wire

// ---- core/oam_core.sv ----
// Operand addressing mode decode and effective address generation
//
// Function
// - Seventeen addressing modes in seven families are supported.
// - Short forms reach page zero, short indexed ones up to 1FE; long forms reach 64 Kbyte.
// - Read-modify-write instructions accept only short addressing forms.
// - Inherent instructions are one byte with no operand fetch.
// - Immediate instructions carry one operand value byte.
// - Short direct fetches one address byte, range 00 to FF.
// - Long direct fetches a two-byte address word.
// - Indexed address is unsigned index plus instruction offset.
// - No-offset indexed uses index alone; Y costs one extra byte.
// - Short indexed adds one-byte offset, range up to 1FE.
// - Long indexed adds a two-byte offset word.
// - Indirect reads a pointer from memory at the following address.
// - Short indirect uses byte pointer address and byte pointer.
// - Long indirect forms use page-zero address, word pointer.
// - Indirect indexed adds index register to the memory pointer.
// - Short indirect indexed yields addresses 00 to 1FE.
// - Relative adds signed displacement to next-instruction program counter.
`timescale 1ns/1ps
`default_nettype none
`include "oam_map.svh"
module oam_core
    import oam_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire oam_mode_e   mode_i,
    input  wire logic        use_y_i,
    input  wire logic        rmw_i,
    input  wire logic [7:0]  x_i,
    input  wire logic [7:0]  y_i,
    input  wire logic [15:0] pc_i,
    output logic [15:0]      mem_addr_o,
    output logic             mem_rd_o,
    input  wire logic [7:0]  mem_data_i,
    input  wire logic        mem_ack_i,
    output logic             busy_o,
    output logic             done_o,
    output logic             illegal_o,
    output logic [15:0]      ea_o,
    output logic [7:0]       imm_o,
    output logic [15:0]      pc_next_o,
    output logic [1:0]       len_o
);
    // =====================================================================
    // Length and adder helpers
    // =====================================================================
    logic [1:0]  nbytes;
    logic        is_ptr;
    logic        is_pword;
    logic        rmw_ok;
    oam_mode_e   mode_reg;
    logic        y_reg;
    logic [7:0]  idx;
    logic [15:0] add_base;
    logic [7:0]  add_off;
    logic        add_signed;
    logic [15:0] add_sum;

    oam_len u_len (
        .mode_i       (mode_reg),
        .use_y_i      (y_reg),
        .opnd_bytes_o (nbytes),
        .ptr_o        (is_ptr),
        .ptr_word_o   (is_pword),
        .rmw_ok_o     (rmw_ok)
    );

    oam_add u_add (
        .base_i   (add_base),
        .index_i  (add_off),
        .signed_i (add_signed),
        .sum_o    (add_sum)
    );

    function automatic logic [15:0] page0(input logic [7:0] b);
        page0 = {`OAM_PAGE_ZERO_HI, b};
    endfunction

    // =====================================================================
    // Sequencer
    // =====================================================================
    oam_state_e  state_reg;
    logic [15:0] pc_reg;
    logic [1:0]  cnt_reg;
    logic [7:0]  b0_reg;
    logic [7:0]  b1_reg;
    logic [7:0]  ph_reg;
    logic        rmw_reg;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mode_reg <= OAM_INH;
            y_reg    <= 1'b0;
            rmw_reg  <= 1'b0;
        end else if (start_i && state_reg == OAM_ST_IDLE) begin
            mode_reg <= mode_i;
            y_reg    <= use_y_i;
            rmw_reg  <= rmw_i;
        end
    end

    assign idx = y_reg ? y_i : x_i;

    // Operand bytes are consumed in order; the pointer is read afterwards.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_reg <= OAM_ST_IDLE;
            cnt_reg   <= 2'h0;
        end else begin
            case (state_reg)
                OAM_ST_IDLE: begin
                    if (start_i) begin
                        state_reg <= OAM_ST_OPC;
                    end
                end
                OAM_ST_OPC: begin
                    cnt_reg <= 2'h0;
                    if (rmw_reg && !rmw_ok) begin
                        state_reg <= OAM_ST_DONE;
                    end else if (nbytes == 2'h0) begin
                        state_reg <= OAM_ST_DONE;
                    end else begin
                        state_reg <= OAM_ST_OPA;
                    end
                end
                OAM_ST_OPA: begin
                    if (mem_ack_i) begin
                        cnt_reg <= cnt_reg + 2'h1;
                        if (cnt_reg + 2'h1 == nbytes) begin
                            state_reg <= is_ptr ? OAM_ST_PTRH : OAM_ST_DONE;
                        end
                    end
                end
                OAM_ST_PTRH: begin
                    if (mem_ack_i) begin
                        state_reg <= is_pword ? OAM_ST_PTRL : OAM_ST_DONE;
                    end
                end
                OAM_ST_PTRL: begin
                    if (mem_ack_i) begin
                        state_reg <= OAM_ST_DONE;
                    end
                end
                OAM_ST_DONE: state_reg <= OAM_ST_IDLE;
                default:     state_reg <= OAM_ST_IDLE;
            endcase
        end
    end

    // =====================================================================
    // Operand and pointer capture
    // =====================================================================
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            b0_reg <= 8'h00;
            b1_reg <= 8'h00;
        end else if (state_reg == OAM_ST_OPA && mem_ack_i) begin
            if (cnt_reg == 2'h0) begin
                b0_reg <= mem_data_i;
            end else begin
                b1_reg <= mem_data_i;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ph_reg <= 8'h00;
        end else if (state_reg == OAM_ST_PTRH && mem_ack_i) begin
            ph_reg <= mem_data_i;
        end
    end

    // Program counter steps once per consumed instruction byte
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pc_reg <= `OAM_PC_RESET;
        end else if (start_i && state_reg == OAM_ST_IDLE) begin
            pc_reg <= pc_i + 16'h0001;
        end else if (state_reg == OAM_ST_OPA && mem_ack_i) begin
            pc_reg <= pc_reg + 16'h0001;
        end
    end

    // =====================================================================
    // Memory request
    // =====================================================================
    logic [15:0] ptr_addr;
    assign ptr_addr = page0(b0_reg);

    always_comb begin
        mem_rd_o   = 1'b0;
        mem_addr_o = pc_reg;
        case (state_reg)
            OAM_ST_OPA: mem_rd_o = 1'b1;
            OAM_ST_PTRH: begin
                mem_rd_o   = 1'b1;
                mem_addr_o = ptr_addr;
            end
            OAM_ST_PTRL: begin
                mem_rd_o   = 1'b1;
                mem_addr_o = ptr_addr + 16'h0001;
            end
            default: mem_rd_o = 1'b0;
        endcase
    end

    // =====================================================================
    // Effective address
    // =====================================================================
    logic [15:0] ea_next;
    logic [15:0] word_ptr;
    logic [7:0]  op0;
    logic [7:0]  op1;
    // The byte of the current beat is not yet in the capture registers
    assign op0 = (state_reg == OAM_ST_OPA && cnt_reg == 2'h0) ? mem_data_i : b0_reg;
    assign op1 = (state_reg == OAM_ST_OPA && cnt_reg == 2'h1) ? mem_data_i : b1_reg;
    // The low pointer byte arrives on the bus in the last pointer read
    assign word_ptr = {ph_reg, mem_data_i};

    always_comb begin
        add_base   = 16'h0000;
        add_off    = idx;
        add_signed = 1'b0;
        ea_next    = 16'h0000;
        case (mode_reg)
            OAM_DIR_S, OAM_BIT_D, OAM_BITREL_D: ea_next = page0(op0);
            OAM_DIR_L: ea_next = {op0, op1};
            OAM_IDX_N: ea_next = page0(idx);
            OAM_IDX_S: begin
                // Carry out of the low byte is kept, giving up to 1FE
                add_base = page0(op0);
                ea_next  = add_sum;
            end
            OAM_IDX_L: begin
                add_base = {op0, op1};
                ea_next  = add_sum;
            end
            OAM_IND_S, OAM_BIT_I, OAM_BITREL_I: ea_next = page0(mem_data_i);
            OAM_IND_L: ea_next = word_ptr;
            OAM_INDX_S: begin
                add_base = page0(mem_data_i);
                ea_next  = add_sum;
            end
            OAM_INDX_L: begin
                add_base = word_ptr;
                ea_next  = add_sum;
            end
            OAM_REL_D: begin
                add_base   = pc_reg + 16'h0001;
                add_off    = mem_data_i;
                add_signed = 1'b1;
                ea_next    = add_sum;
            end
            OAM_REL_I: begin
                add_base   = pc_reg;
                add_off    = mem_data_i;
                add_signed = 1'b1;
                ea_next    = add_sum;
            end
            default: ea_next = 16'h0000;
        endcase
    end

    logic last_beat;
    assign last_beat = mem_ack_i && (
        (state_reg == OAM_ST_PTRL) ||
        (state_reg == OAM_ST_PTRH && !is_pword) ||
        (state_reg == OAM_ST_OPA && cnt_reg + 2'h1 == nbytes && !is_ptr));

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ea_o <= 16'h0000;
        end else if (state_reg == OAM_ST_OPC) begin
            // Forms without operand bytes finish here, so their address lands now
            ea_o <= (nbytes == 2'h0) ? ea_next : 16'h0000;
        end else if (last_beat) begin
            ea_o <= ea_next;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            imm_o <= 8'h00;
        end else if (mode_reg == OAM_IMM && state_reg == OAM_ST_OPA && mem_ack_i) begin
            imm_o <= mem_data_i;
        end
    end

    // =====================================================================
    // Completion outputs
    // =====================================================================
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            done_o    <= 1'b0;
            illegal_o <= 1'b0;
            pc_next_o <= `OAM_PC_RESET;
            len_o     <= 2'h0;
        end else begin
            done_o <= (state_reg == OAM_ST_DONE);
            if (state_reg == OAM_ST_DONE) begin
                pc_next_o <= pc_reg;
                len_o     <= nbytes;
                illegal_o <= rmw_reg && !rmw_ok;
            end
        end
    end

    assign busy_o = (state_reg != OAM_ST_IDLE);

    // =====================================================================
    // Checks
    // =====================================================================
    inherent_len_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_reg == OAM_ST_OPC && mode_reg == OAM_INH) |=> state_reg == OAM_ST_DONE)
        else $error("inherent fetched operand");
    rmw_long_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_reg == OAM_ST_OPC && rmw_reg && mode_reg == OAM_DIR_L)
        |=> ##1 illegal_o)
        else $error("long form accepted for rmw");
    direct_page_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (last_beat && mode_reg == OAM_DIR_S) |=> ea_o[15:8] == 8'h00)
        else $error("short direct left page zero");
    idx_range_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (last_beat && mode_reg == OAM_IDX_S) |=> ea_o <= 16'h01fe)
        else $error("short indexed beyond 1fe");
    idx_sum_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (last_beat && mode_reg == OAM_IDX_S)
        |=> ea_o == {8'h00, $past(mem_data_i)} + {8'h00, $past(idx)})
        else $error("short indexed sum wrong");
    pc_step_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_reg == OAM_ST_OPA && mem_ack_i) |=> pc_reg == $past(pc_reg) + 16'h0001)
        else $error("pc did not step");
    ptr_page_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_reg == OAM_ST_PTRH) |-> mem_addr_o[15:8] == 8'h00)
        else $error("pointer address outside page zero");
    rel_target_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (last_beat && mode_reg == OAM_REL_D)
        |=> ea_o == $past(pc_reg) + 16'h0001 + {{8{$past(mem_data_i[7])}}, $past(mem_data_i)})
        else $error("relative target wrong");
    done_pulse_a: assert property (@(posedge clock_i) disable iff (rst_i)
        done_o |=> !done_o)
        else $error("done held too long");
endmodule
`default_nettype wire

// ---- testbench/oam_mem_model.sv ----
// Behavioural program and data memory answering the operand address unit
`timescale 1ns/1ps
`default_nettype none
module oam_mem_model (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        rd_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [3:0]  lat_i,
    output logic [7:0]       data_o,
    output logic             ack_o
);
    // ==========================================
    // Storage and read answer
    logic [7:0] bytes [0:65535];
    logic [3:0] wait_reg;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            wait_reg <= 4'h0;
            data_o <= 8'h5a;
        end else if (ack_o || !rd_i) begin
            // Data is valid only with ack; invert it each cycle so a stale byte shows at most every other cycle
            ack_o <= 1'b0;
            wait_reg <= 4'h0;
            data_o <= ~data_o;
        end else if (wait_reg == lat_i) begin
            ack_o <= 1'b1;
            wait_reg <= 4'h0;
            data_o <= bytes[addr_i];
        end else begin
            wait_reg <= wait_reg + 4'h1;
            data_o <= ~data_o;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/cpu_operand_address_modes_bench.sv ----
// Self-checking bench for the operand address mode unit
`timescale 1ns/1ps
`default_nettype none
module cpu_operand_address_modes_bench
    import oam_pkg::*;
;
    // ==========================================
    // Signals
    logic        clock, rst, start, use_y, rmw;
    oam_mode_e   mode;
    logic [7:0]  x, y;
    logic [15:0] pc;
    logic [3:0]  lat;
    wire  logic [15:0] mem_addr, ea, pc_next;
    wire  logic [7:0]  mem_data, imm;
    wire  logic [1:0]  len;
    wire  logic        mem_rd, mem_ack, busy, done, illegal;
    int          mismatches, n_checks, n_reads;

    oam_core DUT (.clock_i(clock), .rst_i(rst), .start_i(start), .mode_i(mode),
        .use_y_i(use_y), .rmw_i(rmw), .x_i(x), .y_i(y), .pc_i(pc),
        .mem_addr_o(mem_addr), .mem_rd_o(mem_rd), .mem_data_i(mem_data),
        .mem_ack_i(mem_ack), .busy_o(busy), .done_o(done), .illegal_o(illegal),
        .ea_o(ea), .imm_o(imm), .pc_next_o(pc_next), .len_o(len));

    oam_mem_model MEM (.clock_i(clock), .rst_i(rst), .rd_i(mem_rd), .addr_i(mem_addr),
        .lat_i(lat), .data_o(mem_data), .ack_o(mem_ack));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    always @(posedge clock) begin
        if (mem_rd === 1'b1 && mem_ack === 1'b1) n_reads++;
    end

    // ==========================================
    // Shared tasks
    task automatic close_out;
        $display("Checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic put(input logic [15:0] a, input logic [7:0] v);
        MEM.bytes[a] = v;
    endtask

    // A second start while busy must be dropped when poke is set
    task automatic run(input oam_mode_e m, input logic r, input logic [15:0] p,
                       input logic [7:0] xv, input logic poke);
        int k;
        n_reads = 0;
        @(posedge clock);
        mode <= m;
        rmw <= r;
        pc <= p;
        x <= xv;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        if (poke) begin
            @(posedge clock);
            mode <= OAM_INH;
            start <= 1'b1;
            @(posedge clock);
            start <= 1'b0;
        end
        for (k = 0; k < 100 && done !== 1'b1; k++) begin
            @(posedge clock);
            #1;
        end
        if (done !== 1'b1) begin
            mismatches++;
            $display("Error done expected 1 seen %b", done);
            close_out();
        end
    endtask

    task automatic res(input logic ce, input logic [15:0] e, input logic [1:0] l,
                       input logic [15:0] pn, input int rd);
        if (ce) chk("ea", e, ea);
        chk("len", {14'h0, l}, {14'h0, len});
        chk("pc_next", pn, pc_next);
        chk("reads", 16'(rd), 16'(n_reads));
        chk("illegal", 16'h0, {15'h0, illegal});
        @(posedge clock);
        #1;
        chk("done", 16'h0, {15'h0, done});
    endtask

    // ==========================================
    // Scenarios
    task automatic sc_inh_imm;
        put(16'h0101, 8'h3c);
        run(OAM_INH, 1'b0, 16'h0100, 8'h00, 1'b0);
        res(1'b0, 16'h0, 2'h0, 16'h0101, 0);
        run(OAM_IMM, 1'b0, 16'h0100, 8'h00, 1'b0);
        res(1'b0, 16'h0, 2'h1, 16'h0102, 1);
        chk("imm", 16'h003c, {8'h0, imm});
    endtask

    task automatic sc_direct;
        put(16'h0201, 8'hab);
        put(16'h0301, 8'h12);
        put(16'h0302, 8'h34);
        run(OAM_DIR_S, 1'b0, 16'h0200, 8'h00, 1'b0);
        res(1'b1, 16'h00ab, 2'h1, 16'h0202, 1);
        run(OAM_DIR_L, 1'b0, 16'h0300, 8'h00, 1'b0);
        res(1'b1, 16'h1234, 2'h2, 16'h0303, 2);
    endtask

    task automatic sc_indexed;
        put(16'h0501, 8'hff);
        put(16'h0601, 8'h12);
        put(16'h0602, 8'hf0);
        run(OAM_IDX_N, 1'b0, 16'h0400, 8'h7f, 1'b0);
        res(1'b1, 16'h007f, 2'h0, 16'h0401, 0);
        run(OAM_IDX_S, 1'b0, 16'h0500, 8'hff, 1'b0);
        res(1'b1, 16'h01fe, 2'h1, 16'h0502, 1);
        run(OAM_IDX_L, 1'b0, 16'h0600, 8'h20, 1'b0);
        res(1'b1, 16'h1310, 2'h2, 16'h0603, 2);
    endtask

    task automatic sc_indirect;
        lat = 4'h2;
        put(16'h0701, 8'h40);
        put(16'h0040, 8'h9c);
        put(16'h0801, 8'h41);
        put(16'h0041, 8'hab);
        put(16'h0042, 8'hcd);
        put(16'h0901, 8'h50);
        put(16'h0050, 8'hff);
        put(16'h0a01, 8'h60);
        put(16'h0060, 8'h10);
        put(16'h0061, 8'h00);
        run(OAM_IND_S, 1'b0, 16'h0700, 8'h00, 1'b0);
        res(1'b1, 16'h009c, 2'h1, 16'h0702, 2);
        run(OAM_IND_L, 1'b0, 16'h0800, 8'h00, 1'b0);
        res(1'b1, 16'habcd, 2'h1, 16'h0802, 3);
        run(OAM_INDX_S, 1'b0, 16'h0900, 8'hff, 1'b0);
        res(1'b1, 16'h01fe, 2'h1, 16'h0902, 2);
        run(OAM_INDX_L, 1'b0, 16'h0a00, 8'h10, 1'b0);
        res(1'b1, 16'h1010, 2'h1, 16'h0a02, 3);
        lat = 4'h0;
    endtask

    task automatic sc_relative;
        put(16'h1001, 8'h80);
        put(16'h2001, 8'h7f);
        put(16'h3001, 8'h40);
        put(16'h0040, 8'h9c);
        run(OAM_REL_D, 1'b0, 16'h1000, 8'h00, 1'b0);
        res(1'b1, 16'h0f82, 2'h1, 16'h1002, 1);
        run(OAM_REL_D, 1'b0, 16'h2000, 8'h00, 1'b0);
        res(1'b1, 16'h2081, 2'h1, 16'h2002, 1);
        run(OAM_REL_I, 1'b0, 16'h3000, 8'h00, 1'b0);
        res(1'b1, 16'h2f9e, 2'h1, 16'h3002, 2);
    endtask

    task automatic sc_rmw;
        oam_mode_e lf [4] = '{OAM_DIR_L, OAM_IDX_L, OAM_IND_L, OAM_INDX_L};
        foreach (lf[i]) begin
            run(lf[i], 1'b1, 16'h0300, 8'h00, 1'b0);
            chk("illegal", 16'h1, {15'h0, illegal});
            chk("reads", 16'h0, 16'(n_reads));
        end
        run(OAM_DIR_S, 1'b1, 16'h0200, 8'h00, 1'b0);
        res(1'b1, 16'h00ab, 2'h1, 16'h0202, 1);
    endtask

    task automatic sc_all_modes;
        int m;
        logic [1:0] exp_len [17] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h1, 2'h1,
                                     2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
        put(16'h0b01, 8'h70);
        put(16'h0b02, 8'h70);
        put(16'h0b03, 8'h70);
        put(16'h0070, 8'h00);
        put(16'h0071, 8'h00);
        for (m = 0; m < 17; m++) begin
            use_y <= m[0];
            run(oam_mode_e'(m[4:0]), 1'b0, 16'h0b00, 8'h01, 1'b0);
            chk("illegal", 16'h0, {15'h0, illegal});
            chk("len", {14'h0, exp_len[m]}, {14'h0, len});
            chk("pc_next", 16'h0b01 + {14'h0, exp_len[m]}, pc_next);
        end
        use_y <= 1'b0;
    endtask

    task automatic sc_refuse;
        lat = 4'h3;
        run(OAM_IND_L, 1'b0, 16'h0800, 8'h00, 1'b1);
        res(1'b1, 16'habcd, 2'h1, 16'h0802, 3);
        lat = 4'h0;
    endtask

    task automatic sc_reset;
        lat = 4'h3;
        @(posedge clock);
        mode <= OAM_DIR_L;
        pc <= 16'h0300;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        repeat (3) @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        #1;
        chk("busy", 16'h0, {15'h0, busy});
        chk("ea", 16'h0, ea);
        chk("pc_next", 16'h0, pc_next);
        lat = 4'h0;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        rst = 1'b1;
        start = 1'b0;
        mode = OAM_INH;
        use_y = 1'b0;
        rmw = 1'b0;
        x = 8'h00;
        y = 8'h00;
        pc = 16'h0000;
        lat = 4'h0;
        mismatches = 0;
        n_checks = 0;
        n_reads = 0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        sc_inh_imm();
        sc_direct();
        sc_indexed();
        sc_reset();
        sc_indirect();
        sc_relative();
        sc_rmw();
        sc_all_modes();
        sc_refuse();
        close_out();
    end
endmodule
`default_nettype wire
